// file: pkg/pm_pkg.sv
/*
  constants, register map and state type of the power-state controller.
  assumes a 50 mhz pclk and a word-aligned apb register map.
*/
package pm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ       = 50_000;      // pclk rate in khz
  localparam int WAKE_PULSE_MS = 50;          // pulsed wake pin width
  localparam int READY_MS      = 2;           // resume to ready, longest
  localparam int WAKE_PULSE_CYC = WAKE_PULSE_MS * CLK_KHZ;
  localparam int READY_CYC      = READY_MS * CLK_KHZ;  // exact integer product
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PMCTRL = 8'h00;  // power mgmt control
  localparam logic [7:0] OFS_BTEST  = 8'h04;  // byte-order test, wakes
  localparam logic [7:0] OFS_INTSTS = 8'h08;  // interrupt status
  localparam logic [7:0] OFS_INTEN  = 8'h0c;  // interrupt enable
  localparam logic [7:0] OFS_PHYCTL = 8'h10;  // phy power control
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_READY = 0;   // ready flag, read only
  localparam int B_PINEN = 1;   // wake pin enable
  localparam int B_PULSE = 2;   // wake_pin_pulse_select
  localparam int B_WAKEUP_SOURCE_STATUS  = 4;   // wakeup_source_status, two bits, w1c
  localparam int B_WFEN  = 8;   // wake_frame_detect_enable
  localparam int B_EDEN  = 9;   // energy_detect_wake_enable
  localparam int B_PSEL  = 12;  // power_state_select, two bits
  localparam int B_WINT  = 0;   // wake interrupt status / enable
  localparam int B_GPD   = 0;   // phy general power-down
  localparam int B_EDPD  = 1;   // energy_detect_powerdown
  localparam int B_ENRG  = 2;   // line_energy_present, read only
  localparam int B_EINT  = 3;   // energy interrupt source flag, w1c
  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PSEL_D0   = 2'h0;
  localparam logic [1:0] PSEL_D1   = 2'h1;
  localparam logic [1:0] PSEL_D2   = 2'h2;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_NONE = 2'h0;
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_ED   = 2'h1;  // energy detected
  localparam logic [1:0] WAKEUP_SOURCE_STATUS_WOL  = 2'h2;  // wake frame / magic packet
  localparam logic [31:0] BTEST_PATTERN = 32'h0123_4567; // arbitrary
  typedef enum logic [1:0] {ST_D0, ST_D1, ST_D2} power_state_e;
endpackage : pm_pkg

// file: pkg/countdown_if.sv
/*
  start/expire carrier between the controller and a countdown timer.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface countdown_if;
  logic start;    // one-cycle pulse, (re)loads the count
  logic running;  // count in progress
  logic expired;  // one-cycle pulse at the end of the count
  modport ctl (output start, input running, expired);
  modport tmr (input start, output running, expired);
endinterface : countdown_if
`default_nettype wire

// file: verilog/pin_sync3.sv
/*
  three-flop synchroniser for an asynchronous pin level.
  assumes the pin is slow against pclk; output updates once the
  second and third flops agree.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output var  logic level_q
);
  logic s1_q, s2_q, s3_q;  // chain; s1 feeds s2 only
  logic level_d;
  // ----------------------------------------------------------------
  // agreement filter
  // ----------------------------------------------------------------
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q    <= pin;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end
endmodule : pin_sync3
`default_nettype wire

// file: verilog/countdown_timer.sv
/*
  retriggerable countdown of COUNT cycles.
  assumes start is a single-cycle pulse from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module countdown_timer #(
  parameter int COUNT = 16
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  countdown_if.tmr   tm
);
  localparam int W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LOAD = W'(COUNT);
  logic [W-1:0] cnt_q, cnt_d;   // cycles left
  logic         run_d, exp_d;
  // the logic needs at least one cycle of count
  if (COUNT < 1) begin : g_chk
    $error("countdown_timer: COUNT must be at least 1");
  end
  // ----------------------------------------------------------------
  // count
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (tm.start) begin
      cnt_d = LOAD;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      exp_d = (cnt_q == W'(1));
    end
    run_d = (cnt_d != '0);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= '0;
      tm.running <= 1'b0;
      tm.expired <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      tm.running <= run_d;
      tm.expired <= exp_d;
    end
  end
endmodule : countdown_timer
`default_nettype wire

// file: verilog/power_state_wake_control.sv
/*
  power-state controller: d0/d1/d2 states, clock gating, ready flag,
  host write gating, wake pin and wake interrupt, phy power-down.
  assumes an apb master on pclk, same-clock wake detect pulses from the
  frame filter, and line energy arriving as an asynchronous pin.
*/
// What this block does
// (R01) one normal, two sleep states; sleep clears ready
// (R02) host reads only control register while not ready
// (R03) host writes only the wake write while not ready
// (R04) writes ignored until a read after reset/wake
// (R05) byte-test write in sleep returns to d0
// (R06) writing 01 to state select enters d1
// (R07) d1 keeps phy and mac wake clocks
// (R08) d1 detection sets source 10, drives pin
// (R09) any wake event sets wake interrupt status
// (R10) host sets phy powerdown, then selects 10
// (R11) d2 stops mac and bus clocks, clears ready
// (R12) d2 energy sets source 01, drives pin
// (R13) host clears phy powerdown only after ready
// (R14) host may clear wake source once ready
// (R15) wake status sticks while source active, w1c
// (R16) pulse select gives 50ms pin, else static
// (R17) pin drops on source, enable, pin-enable clear
// (R18) general powerdown holds phy off, reset on clear
// (R19) energy powerdown: phy off without energy, flag
// (R20) wake source status readable by software
// (R21) ready set within 2ms after wake write
// (R22) state select 00 is d0, read after wake
`timescale 1ns/1ps
`default_nettype none
module power_state_wake_control
  import pm_pkg::*;
#(
  parameter int PULSE_CYC = WAKE_PULSE_CYC,  // wake pin pulse, cycles
  parameter int RDY_CYC   = READY_CYC        // resume to ready, cycles
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        wake_frame_seen,   // pulse, frame filter
  input  wire logic        magic_packet_seen, // pulse, frame filter
  input  wire logic        line_energy_present, // async pin
  output var  logic        wake_pin,
  output var  logic        host_irq,
  output var  logic        device_ready,
  output var  logic        core_clk_en,
  output var  logic        mac_pm_clk_en,
  output var  logic        phy_clk_en,
  output var  logic        phy_power_down,
  output var  logic        phy_reset
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  power_state_e st_q, st_d;            // power state
  logic        rdy_q, rdy_d;           // ready flag
  logic        seen_q, seen_d;         // a read happened since reset/wake
  logic        pinen_q, pinen_d;       // wake pin enable
  logic        pulse_q, pulse_d;       // wake_pin_pulse_select
  logic [1:0]  wakeup_source_status_q, wakeup_source_status_d;         // wakeup_source_status
  logic        wfen_q, wfen_d;         // wake_frame_detect_enable
  logic        eden_q, eden_d;         // energy_detect_wake_enable
  logic        wint_q, wint_d;         // wake interrupt status
  logic        wien_q, wien_d;         // wake interrupt enable
  logic        gpd_q, gpd_d;           // phy general power-down
  logic        edpd_q, edpd_d;         // energy_detect_powerdown
  logic        eint_q, eint_d;         // phy energy interrupt flag
  logic        enrg_prev_q;            // energy level, last cycle
  logic        boot_q;                 // starts the ready timer at reset
  logic [31:0] rdata_d;
  logic        rdy_ack_d, err_d;
  logic        enrg;                   // synchronised line energy
  logic        acc, wr, rd, wr_ok, wake_wr;
  logic        det_wol, det_ed, wake_ev, src;
  logic [1:0]  psel_f;
  countdown_if pulse_tm ();            // wake pin pulse
  countdown_if ready_tm ();            // resume delay

  if (PULSE_CYC < 1 || RDY_CYC < 1) begin : g_chk
    $error("power_state_wake_control: counts must be at least 1");
  end

  pin_sync3 u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (line_energy_present),
    .level_q (enrg)
  );
  countdown_timer #(.COUNT(PULSE_CYC)) u_pulse (
    .pclk    (pclk),
    .presetn (presetn),
    .tm      (pulse_tm.tmr)
  );
  countdown_timer #(.COUNT(RDY_CYC)) u_ready (
    .pclk    (pclk),
    .presetn (presetn),
    .tm      (ready_tm.tmr)
  );

  // ----------------------------------------------------------------
  // bus decode: answer in the second access cycle
  // ----------------------------------------------------------------
  assign acc     = psel & penable & ~pready;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign psel_f  = pwdata[B_PSEL +: 2];
  // (R05) wake write taken in sleep regardless of the read gate
  assign wake_wr = wr & (paddr == OFS_BTEST) & (st_q != ST_D0);
  // (R04) (R03) writes need a prior read and the ready flag
  assign wr_ok   = wr & seen_q & rdy_q;

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  // (R08) d1 detection is always armed, enables only gate outputs
  assign det_wol = (st_q == ST_D1) & (wake_frame_seen | magic_packet_seen);
  // (R12) level based, so carrier present on entry detects at once
  assign det_ed  = (st_q == ST_D2) & enrg;
  assign wake_ev = (det_wol & (wakeup_source_status_q != WAKEUP_SOURCE_STATUS_WOL))
                 | (det_ed & (wakeup_source_status_q != WAKEUP_SOURCE_STATUS_ED));
  // (R15) internal interrupt source, also the pin's source
  assign src     = (wakeup_source_status_q[1] & wfen_q) | (wakeup_source_status_q[0] & eden_q);
  assign pulse_tm.start = wake_ev;
  assign ready_tm.start = wake_wr | boot_q;

  // ----------------------------------------------------------------
  // next values of the control state; outputs are formed in the register block
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    rdy_d   = rdy_q;
    seen_d  = seen_q | rd;
    pinen_d = pinen_q;
    pulse_d = pulse_q;
    wakeup_source_status_d  = wakeup_source_status_q;
    wfen_d  = wfen_q;
    eden_d  = eden_q;
    wien_d  = wien_q;
    gpd_d   = gpd_q;
    edpd_d  = edpd_q;
    wint_d  = wint_q;
    eint_d  = eint_q;
    // software writes
    if (wr_ok) begin
      unique case (paddr)
        OFS_PMCTRL: begin
          pinen_d = pwdata[B_PINEN];
          pulse_d = pwdata[B_PULSE];
          wfen_d  = pwdata[B_WFEN];
          eden_d  = pwdata[B_EDEN];
          // (R14) source bits are write-one-to-clear
          wakeup_source_status_d  = wakeup_source_status_q & ~pwdata[B_WAKEUP_SOURCE_STATUS +: 2];
          if (st_q == ST_D0) begin
            // (R06) 01 enters d1; (R10) 10 enters d2; 11 ignored
            if (psel_f == PSEL_D1) begin
              st_d = ST_D1;
            end else if (psel_f == PSEL_D2) begin
              st_d = ST_D2;
            end
          end
        end
        OFS_INTSTS: begin
          wint_d = wint_q & ~pwdata[B_WINT];
          eint_d = eint_q & ~pwdata[B_EINT];
        end
        OFS_INTEN:  wien_d = pwdata[B_WINT];
        OFS_PHYCTL: begin
          gpd_d  = pwdata[B_GPD];
          edpd_d = pwdata[B_EDPD];
        end
        default: ;
      endcase
    end
    // (R08) (R12) hardware sets the source field over any clear
    if (det_wol) begin
      wakeup_source_status_d = WAKEUP_SOURCE_STATUS_WOL;
    end else if (det_ed) begin
      wakeup_source_status_d = WAKEUP_SOURCE_STATUS_ED;
    end
    // (R09) (R15) set wins over the w1c, held while source active
    if (wake_ev | src) begin
      wint_d = 1'b1;
    end
    // (R19) energy arrival under energy power-down raises the flag
    if (edpd_q & enrg & ~enrg_prev_q) begin
      eint_d = 1'b1;
    end
    // (R01) (R11) ready drops on sleep entry
    if (st_d != ST_D0) begin
      rdy_d = 1'b0;
    end else if (ready_tm.expired) begin
      // (R21) ready returns when the resume delay expires
      rdy_d = 1'b1;
    end
    // (R05) (R22) wake write returns to d0, select reads 00
    if (wake_wr) begin
      st_d   = ST_D0;
      rdy_d  = 1'b0;
      seen_d = 1'b0;  // (R04) a fresh read is needed after waking
    end
  end

  // ----------------------------------------------------------------
  // read mux; only the control register answers while not ready
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    err_d   = 1'b0;
    unique case (paddr)
      OFS_PMCTRL: begin
        rdata_d[B_READY]     = rdy_q;
        rdata_d[B_PINEN]     = pinen_q;
        rdata_d[B_PULSE]     = pulse_q;
        // (R20) software sees which wake source drives the pin
        rdata_d[B_WAKEUP_SOURCE_STATUS +: 2] = wakeup_source_status_q;
        rdata_d[B_WFEN]      = wfen_q;
        rdata_d[B_EDEN]      = eden_q;
        // (R22) d0 reports 00
        rdata_d[B_PSEL +: 2] = (st_q == ST_D1) ? PSEL_D1 :
                               (st_q == ST_D2) ? PSEL_D2 : PSEL_D0;
      end
      OFS_BTEST:  rdata_d = BTEST_PATTERN;
      OFS_INTSTS: begin
        rdata_d[B_WINT] = wint_q;
        rdata_d[B_EINT] = eint_q;
      end
      OFS_INTEN:  rdata_d[B_WINT] = wien_q;
      OFS_PHYCTL: begin
        rdata_d[B_GPD]  = gpd_q;
        rdata_d[B_EDPD] = edpd_q;
        rdata_d[B_ENRG] = enrg;
      end
      default:    err_d = 1'b1;
    endcase
    // (R02) other registers read zero while the flag is clear
    if (!rdy_q && paddr != OFS_PMCTRL) begin
      rdata_d = '0;
    end
    rdy_ack_d = acc;
  end

  // ----------------------------------------------------------------
  // registers; outputs are flops, so they trail state by one cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_D0;
      {rdy_q, seen_q, pinen_q, pulse_q} <= 4'h0;
      {wfen_q, eden_q, wint_q, wien_q}  <= 4'h0;
      {gpd_q, edpd_q, eint_q}           <= 3'h0;
      wakeup_source_status_q        <= WAKEUP_SOURCE_STATUS_NONE;
      enrg_prev_q   <= 1'b0;
      boot_q        <= 1'b1;
      prdata        <= '0;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      wake_pin      <= 1'b0;
      host_irq      <= 1'b0;
      device_ready  <= 1'b0;
      core_clk_en   <= 1'b1;
      mac_pm_clk_en <= 1'b1;
      phy_clk_en    <= 1'b1;
      phy_power_down <= 1'b0;
      phy_reset     <= 1'b0;
    end else begin
      st_q    <= st_d;
      rdy_q   <= rdy_d;
      seen_q  <= seen_d;
      pinen_q <= pinen_d;
      pulse_q <= pulse_d;
      wakeup_source_status_q  <= wakeup_source_status_d;
      wfen_q  <= wfen_d;
      eden_q  <= eden_d;
      wint_q  <= wint_d;
      wien_q  <= wien_d;
      gpd_q   <= gpd_d;
      edpd_q  <= edpd_d;
      eint_q  <= eint_d;
      enrg_prev_q <= enrg;
      boot_q  <= 1'b0;
      prdata  <= rd ? rdata_d : 32'h0000_0000;
      pready  <= rdy_ack_d;
      pslverr <= acc & err_d;
      // (R16) (R17) pulsed or static pin, gated by source and enable
      wake_pin <= src & pinen_q & (~pulse_q | pulse_tm.running);
      host_irq <= wint_q & wien_q;  // (R09) independent of the pin
      device_ready <= rdy_q;
      // (R07) (R11) clock gating per state
      core_clk_en   <= (st_q == ST_D0);
      mac_pm_clk_en <= (st_q != ST_D2);
      // (R19) energy power-down keeps only sensing alive
      phy_clk_en    <= ~gpd_q & ~(edpd_q & ~enrg);
      // (R18) held down while set, self reset when released
      phy_power_down <= gpd_q | (edpd_q & ~enrg);
      phy_reset     <= (gpd_q & ~gpd_d) | (edpd_q & enrg & ~enrg_prev_q);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] lo_cnt_q;  // cycles ready low in d0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_cnt_q <= '0;
    else lo_cnt_q <= (st_q == ST_D0 && !rdy_q) ? lo_cnt_q + 1 : '0;
  end
  ready_sleep_a: assert property (st_q != ST_D0 |-> !rdy_q) // (R01)
    else $error("ready set while asleep");
  write_gate_a: assert property (wr && !seen_q && st_q == ST_D0 // (R04)
      && paddr == OFS_PMCTRL |=> $stable(pinen_q))
    else $error("write taken before a read");
  wake_d0_a: assert property (wake_wr |=> st_q == ST_D0 && // (R05)
      !core_clk_en ##1 core_clk_en)
    else $error("wake write did not return to d0");
  enter_d1_a: assert property (wr_ok && paddr == OFS_PMCTRL // (R06)
      && psel_f == PSEL_D1 && st_q == ST_D0 |=> st_q == ST_D1 && !rdy_q)
    else $error("d1 not entered");
  clk_d1_a: assert property (st_q == ST_D1 && !gpd_q && !edpd_q // (R07)
      |=> phy_clk_en && mac_pm_clk_en && !core_clk_en)
    else $error("d1 clocks wrong");
  wakeup_source_status_d1_a: assert property (det_wol |=> wakeup_source_status_q == WAKEUP_SOURCE_STATUS_WOL) // (R08)
    else $error("d1 detect lost");
  int_set_a: assert property (wake_ev |=> wint_q // (R09)
      ##1 host_irq == wien_q)
    else $error("wake interrupt not set");
  pin_static_a: assert property (src && pinen_q && !pulse_q // (R16)
      |=> wake_pin)
    else $error("static wake pin missing");
  pin_off_a: assert property (!src || !pinen_q |=> !wake_pin) // (R17)
    else $error("wake pin not dropped");
  phy_rst_a: assert property (gpd_q && !gpd_d |=> phy_reset) // (R18)
    else $error("phy reset missing after power-down release");
  ready_time_a: assert property (lo_cnt_q <= RDY_CYC + 2) // (R21)
    else $error("ready late after wake");
  d1_entry_c: cover property (st_q == ST_D0 ##1 st_q == ST_D1);
  d2_entry_c: cover property (st_q == ST_D0 ##1 st_q == ST_D2);
  pin_rise_c: cover property ($rose(wake_pin));
  ready_rise_c: cover property (st_q == ST_D0 && !rdy_q ##1 rdy_q);
endmodule : power_state_wake_control
`default_nettype wire

// file: verification/apb_host_model.sv
/*
  host side of the register bus: one blocking apb transfer task.
  assumes pclk from the bench; a transfer is entered after any edge.
*/
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // ----------------------------------------------------------------
  // bus idle at time zero
  // ----------------------------------------------------------------
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end
  // ----------------------------------------------------------------
  // one transfer: setup, then access held until pready at an edge
  // ----------------------------------------------------------------
  // starts on a fresh edge so no signal is assigned twice in a step
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // released psel, penable, paddr and pwdata show a changed value, never the old one
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~wd;
  endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// file: verification/tb_top.sv
/*
  self-checking bench of the power-state controller.
  assumes short pulse and ready counts set at the instance.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import pm_pkg::*;;
  localparam int          PULSE  = 20;
  localparam int          RDY    = 10;
  localparam logic [31:0] PINEN  = 32'h1 << B_PINEN;
  localparam logic [31:0] PULSEB = 32'h1 << B_PULSE;
  localparam logic [31:0] WFEN   = 32'h1 << B_WFEN;
  localparam logic [31:0] EDEN   = 32'h1 << B_EDEN;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        err, wf_seen, mp_seen, energy, wake_pin, host_irq;
  logic        device_ready, core_clk_en, mac_pm_clk_en, phy_clk_en;
  logic        phy_power_down, phy_reset;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          n_errors = 0, checked = 0, cycles = 0, n;
  // ----------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------
  power_state_wake_control #(.PULSE_CYC(PULSE), .RDY_CYC(RDY)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_frame_seen(wf_seen),
    .magic_packet_seen(mp_seen), .line_energy_present(energy),
    .wake_pin(wake_pin), .host_irq(host_irq),
    .device_ready(device_ready), .core_clk_en(core_clk_en),
    .mac_pm_clk_en(mac_pm_clk_en), .phy_clk_en(phy_clk_en),
    .phy_power_down(phy_power_down), .phy_reset(phy_reset));
  apb_host_model i_host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, got);
    checked++;
    if (got !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, got);
      n_errors++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, r, err);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, r, err);
  endtask : rd
  // settled values after n edges
  task automatic step(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : step
  task automatic wait_for(ref logic s, input int lim);
    n = 0;
    #1;
    while (s !== 1'b1 && n < lim) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : wait_for
  // any data to the byte test register wakes; then poll and read
  task automatic wake;
    wr(OFS_BTEST, 32'hffff_ffff);
    wait_for(device_ready, RDY + 4);
    chk("ready_after_wake", 1, device_ready);
    rd(OFS_PMCTRL);
  endtask : wake
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    wait_for(device_ready, RDY + 4);
    wr(OFS_PMCTRL, PINEN);
    rd(OFS_PMCTRL);
    chk("write_before_read", 32'h1, r & (PINEN | 32'h1));
    wr(OFS_PMCTRL, PINEN);
    rd(OFS_PMCTRL);
    chk("write_after_read", PINEN | 32'h1, r & (PINEN | 32'h1));
    wr(OFS_INTEN, 32'h1);
    rd(8'h40);
    chk("unmapped", 32'h1, {r[30:0], err});
  endtask : t_reset
  task automatic t_d1(input logic magic);
    wr(OFS_PMCTRL, PINEN | WFEN | (32'(PSEL_D1) << B_PSEL));
    step(2);
    chk("d1_ready", 0, device_ready);
    chk("d1_clocks", 3'b011, {core_clk_en, mac_pm_clk_en, phy_clk_en});
    @(posedge pclk);
    if (magic) mp_seen <= 1'b1;
    else wf_seen <= 1'b1;
    @(posedge pclk);
    mp_seen <= 1'b0;
    wf_seen <= 1'b0;
    step(3);
    chk("d1_pin_irq", 2'b11, {wake_pin, host_irq});
    rd(OFS_PMCTRL);
    chk("d1_source", WAKEUP_SOURCE_STATUS_WOL, r[B_WAKEUP_SOURCE_STATUS+:2]);
    wake();
    chk("d1_state", PSEL_D0, r[B_PSEL+:2]);
    wr(OFS_INTSTS, 32'h1);
    step(2);
    chk("irq_sticky", 1, host_irq);
    wr(OFS_PMCTRL, PINEN | WFEN | (32'(WAKEUP_SOURCE_STATUS_WOL) << B_WAKEUP_SOURCE_STATUS));
    step(2);
    chk("pin_off", 0, wake_pin);
    wr(OFS_INTSTS, 32'h1);
    step(2);
    chk("irq_clear", 0, host_irq);
  endtask : t_d1
  task automatic t_d2;
    wr(OFS_PHYCTL, 32'h1 << B_EDPD);
    wr(OFS_PMCTRL, PINEN | PULSEB | EDEN | (32'(PSEL_D2) << B_PSEL));
    step(8);
    chk("d2_clocks", 4'h0,
        {device_ready, core_clk_en, mac_pm_clk_en, phy_clk_en});
    @(posedge pclk);
    energy <= 1'b1;
    wait_for(wake_pin, 12);
    chk("d2_pin", 1, wake_pin);
    n = 0;
    while (wake_pin === 1'b1 && n < 4 * PULSE) begin
      step(1);
      n++;
    end
    chk("pulse_len", 1, n >= PULSE - 1 && n <= PULSE + 1);
    chk("phy_up", 1, phy_clk_en);
    rd(OFS_PMCTRL);
    chk("d2_source", WAKEUP_SOURCE_STATUS_ED, r[B_WAKEUP_SOURCE_STATUS+:2]);
    wake();
    rd(OFS_INTSTS);
    chk("d2_interrupt_status_register", 32'h9, r);
    wr(OFS_PHYCTL, 32'h0);
    wr(OFS_PMCTRL, 32'(WAKEUP_SOURCE_STATUS_ED) << B_WAKEUP_SOURCE_STATUS);
    wr(OFS_INTSTS, 32'h9);
    step(2);
    chk("d2_irq_clear", 0, host_irq);
    energy <= 1'b0;
  endtask : t_d2
  task automatic t_phy;
    wr(OFS_PHYCTL, 32'h1 << B_GPD);
    step(2);
    chk("gpd_on", 2'b10, {phy_power_down, phy_clk_en});
    // the reset pulse stands one cycle, so watch it during the write
    fork
      wr(OFS_PHYCTL, 32'h0);
      wait_for(phy_reset, 4);
    join
    chk("gpd_reset", 1, phy_reset);
  endtask : t_phy
  // ----------------------------------------------------------------
  // verdict, clock, timeout, sequence
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {presetn, wf_seen, mp_seen, energy} = 4'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_d1(1'b0);
    t_d1(1'b1);
    t_d2();
    t_phy();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
